//--- inc/afs_consts.svh
// Constants for the axis fault supervisor: offsets, fields, codes and reset values.
`ifndef AFS_CONSTS_SVH
`define AFS_CONSTS_SVH
`define AFS_OFF_CTRL     12'h000
`define AFS_OFF_STATUS   12'h004
`define AFS_OFF_INPUTS   12'h008
`define AFS_OFF_SETPT0   12'h00c
`define AFS_OFF_SETPT1   12'h010
`define AFS_OFF_SETPT2   12'h014
`define AFS_OFF_CLEAR    12'h018
`define AFS_CTRL_POL_LO  0
`define AFS_CTRL_POL_HI  1
`define AFS_CTRL_PROG    2
`define AFS_CTRL_FOLLOW  3
`define AFS_CLEAR_BIT    0
`define AFS_ERR_NONE     4'h0
`define AFS_ERR_LIMIT    4'h3
`define AFS_ERR_FOLLOW   4'h4
`define AFS_ERR_PROG     4'h5
`define AFS_ERR_DRIVE    4'h6
`define AFS_DISP_L       8'h4c
`define AFS_DISP_OK      8'h2e
`define AFS_DISP_F       8'h46
`define AFS_DISP_E       8'h45
`define AFS_SETPT_ZERO   12'h800
`endif

//--- inc/afs_pkg.sv
// Types shared by the axis fault supervisor files.
package afs_pkg;
  typedef enum logic [1:0] {
    AFS_POL_OFF,
    AFS_POL_LOW,
    AFS_POL_HIGH
  } afs_pol_t;
  typedef enum logic [1:0] {
    AFS_HOLD,
    AFS_RUN,
    AFS_TRIP
  } afs_state_t;
endpackage : afs_pkg

//--- hw/afs_sync.sv
// Two flip-flop synchroniser for a bank of asynchronous input pins.
`timescale 1ns/1ps
module afs_sync #(
  parameter int WIDTH = 7
) (
  input  wire logic             i_clk_sys,
  input  wire logic             i_resetn,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] stage1;

  // The first stage is read only by the second stage to keep metastability contained.
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      stage1 <= '0;
      o_sync <= '0;
    end else begin
      stage1 <= i_async;
      o_sync <= stage1;
    end
  end
endmodule : afs_sync

//--- hw/afs_top.sv
// Axis fault supervisor: input supervision, relay, setpoints and APB registers.
//
// Register access over APB and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`include "afs_consts.svh"
module afs_top
  import afs_pkg::*;
#(
  parameter int NAXES = 3,
  parameter int DACW  = 12
) (
  input  wire logic               i_clk_sys,
  input  wire logic               i_resetn,
  input  wire logic               i_psel,
  input  wire logic               i_penable,
  input  wire logic               i_pwrite,
  input  wire logic [11:0]        i_paddr,
  input  wire logic [31:0]        i_pwdata,
  output logic      [31:0]        o_prdata,
  output logic                    o_pready,
  output logic                    o_pslverr,
  input  wire logic [NAXES-1:0]   i_limit_pin,
  input  wire logic [NAXES-1:0]   i_datum_pin,
  input  wire logic               i_drive_fault_pin,
  output logic                    o_relay_energise,
  output logic [NAXES-1:0]        o_axis_enable,
  output logic [NAXES*DACW-1:0]   o_setpoint,
  output logic [7:0]              o_display,
  output afs_pkg::afs_state_t     o_state
);
  import afs_pkg::*;

  // ==========================================================================
  // Input synchronisation
  // ==========================================================================
  localparam int NSYNC = 2 * NAXES + 1;
  logic [NSYNC-1:0] pins_sync;
  logic [NAXES-1:0] limit_high;
  logic [NAXES-1:0] datum_high;
  logic             drive_raw;

  // All field pins are asynchronous to the system clock.
  afs_sync #(.WIDTH(NSYNC)) u_sync (
    .i_clk_sys (i_clk_sys),
    .i_resetn  (i_resetn),
    .i_async   ({i_drive_fault_pin, i_datum_pin, i_limit_pin}),
    .o_sync    (pins_sync)
  );
  assign limit_high = pins_sync[NAXES-1:0];
  assign datum_high = pins_sync[2*NAXES-1:NAXES];
  assign drive_raw  = pins_sync[NSYNC-1];

  // ==========================================================================
  // Fault decode
  // ==========================================================================
  logic [NAXES-1:0] limit_active;
  logic [NAXES-1:0] datum_active;
  logic             limit_fault;
  logic             drive_active;
  logic             prog_err;
  logic             follow_err;
  afs_pol_t         fault_input_polarity;
  logic             any_fault;

  // A low or floating pin means the normally closed switch has opened.
  assign limit_active = ~limit_high;
  assign datum_active = ~datum_high;
  // Datum state is reported only; it is deliberately kept out of the fault term.
  assign limit_fault  = |limit_active;

  // Polarity select decides which pin level counts as a drive fault.
  always_comb begin
    case (fault_input_polarity)
      AFS_POL_LOW:  drive_active = ~drive_raw;
      AFS_POL_HIGH: drive_active = drive_raw;
      default:      drive_active = 1'b0;
    endcase
  end

  assign any_fault = limit_fault | drive_active | prog_err | follow_err;

  // ==========================================================================
  // Supervisor state machine
  // ==========================================================================
  afs_state_t state;
  afs_state_t next_state;
  logic       clear_req;

  // Reset lands in HOLD so the drives stay disabled until software clears it.
  always_comb begin
    next_state = state;
    case (state)
      AFS_HOLD: begin
        if (clear_req && !any_fault) begin
          next_state = AFS_RUN;
        end
      end
      AFS_RUN: begin
        if (any_fault) begin
          next_state = AFS_TRIP;
        end
      end
      AFS_TRIP: begin
        if (clear_req && !any_fault) begin
          next_state = AFS_RUN;
        end
      end
      default: next_state = AFS_HOLD;
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      state <= AFS_HOLD;
    end else begin
      state <= next_state;
    end
  end

  logic running;
  assign running = (state == AFS_RUN) && !any_fault;

  // ==========================================================================
  // Fault outputs
  // ==========================================================================
  logic [3:0]            err_code;
  logic [NAXES*DACW-1:0] setpt_reg;

  // Limit has highest priority so its code and letter win when faults coincide.
  always_comb begin
    if (limit_fault) begin
      err_code = `AFS_ERR_LIMIT;
    end else if (drive_active) begin
      err_code = `AFS_ERR_DRIVE;
    end else if (follow_err) begin
      err_code = `AFS_ERR_FOLLOW;
    end else if (prog_err) begin
      err_code = `AFS_ERR_PROG;
    end else begin
      err_code = `AFS_ERR_NONE;
    end
  end

  // Relay, enables, setpoints and display are registered outputs.
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_relay_energise <= 1'b0;
      o_axis_enable    <= '0;
      o_display        <= `AFS_DISP_E;
    end else begin
      o_relay_energise <= running;
      o_axis_enable    <= {NAXES{running}};
      if (limit_fault) begin
        o_display <= `AFS_DISP_L;
      end else if (any_fault) begin
        o_display <= `AFS_DISP_F;
      end else if (running) begin
        o_display <= `AFS_DISP_OK;
      end else begin
        o_display <= `AFS_DISP_E;
      end
    end
  end

  // Offset binary: mid code is zero volts, so a dropped axis sits at 0V.
  genvar ax;
  generate
    for (ax = 0; ax < NAXES; ax++) begin : g_setpt
      always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
          o_setpoint[ax*DACW +: DACW] <= DACW'(`AFS_SETPT_ZERO);
        end else if (running) begin
          o_setpoint[ax*DACW +: DACW] <= setpt_reg[ax*DACW +: DACW];
        end else begin
          o_setpoint[ax*DACW +: DACW] <= DACW'(`AFS_SETPT_ZERO);
        end
      end
    end
  endgenerate

  assign o_state = state;

  // ==========================================================================
  // APB slave
  // ==========================================================================
  logic wr_en;
  logic rd_en;
  assign wr_en     = i_psel && i_penable && i_pwrite;
  assign rd_en     = i_psel && i_penable && !i_pwrite;
  assign o_pready  = 1'b1;

  function automatic logic addr_known(input logic [11:0] a);
    addr_known = (a == `AFS_OFF_CTRL)   || (a == `AFS_OFF_STATUS) ||
                 (a == `AFS_OFF_INPUTS) || (a == `AFS_OFF_SETPT0) ||
                 (a == `AFS_OFF_SETPT1) || (a == `AFS_OFF_SETPT2) ||
                 (a == `AFS_OFF_CLEAR);
  endfunction : addr_known

  assign o_pslverr = i_psel && i_penable && !addr_known(i_paddr);

  // Control register: drive fault sense and software-raised faults.
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      fault_input_polarity <= AFS_POL_OFF;
      prog_err             <= 1'b0;
      follow_err           <= 1'b0;
    end else if (wr_en && i_paddr == `AFS_OFF_CTRL) begin
      if (i_pwdata[`AFS_CTRL_POL_HI]) begin
        fault_input_polarity <= AFS_POL_HIGH;
      end else if (i_pwdata[`AFS_CTRL_POL_LO]) begin
        fault_input_polarity <= AFS_POL_LOW;
      end else begin
        fault_input_polarity <= AFS_POL_OFF;
      end
      prog_err   <= i_pwdata[`AFS_CTRL_PROG];
      follow_err <= i_pwdata[`AFS_CTRL_FOLLOW];
    end
  end

  // The clear strobe is a one-cycle pulse; it never lives past the access.
  assign clear_req = wr_en && (i_paddr == `AFS_OFF_CLEAR) && i_pwdata[`AFS_CLEAR_BIT];

  // Setpoint codes held per axis, applied only while running.
  generate
    for (ax = 0; ax < NAXES; ax++) begin : g_setreg
      always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
          setpt_reg[ax*DACW +: DACW] <= DACW'(`AFS_SETPT_ZERO);
        end else if (wr_en && i_paddr == 12'(`AFS_OFF_SETPT0 + 4 * ax)) begin
          setpt_reg[ax*DACW +: DACW] <= i_pwdata[DACW-1:0];
        end
      end
    end
  endgenerate

  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (i_paddr)
      `AFS_OFF_CTRL: begin
        rd_mux[`AFS_CTRL_POL_LO] = (fault_input_polarity == AFS_POL_LOW);
        rd_mux[`AFS_CTRL_POL_HI] = (fault_input_polarity == AFS_POL_HIGH);
        rd_mux[`AFS_CTRL_PROG]   = prog_err;
        rd_mux[`AFS_CTRL_FOLLOW] = follow_err;
      end
      `AFS_OFF_STATUS: rd_mux = {16'h0000, o_display, 2'b00, state, err_code};
      `AFS_OFF_INPUTS: rd_mux = 32'({drive_active, datum_active, limit_active});
      `AFS_OFF_SETPT0: rd_mux = 32'(setpt_reg[0*DACW +: DACW]);
      `AFS_OFF_SETPT1: rd_mux = 32'(setpt_reg[1*DACW +: DACW]);
      `AFS_OFF_SETPT2: rd_mux = 32'(setpt_reg[2*DACW +: DACW]);
      default:         rd_mux = 32'h0000_0000;
    endcase
  end

  // Read data is registered in the setup cycle and held afterwards.
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_prdata <= 32'h0000_0000;
    end else if (i_psel && !i_penable && !i_pwrite) begin
      o_prdata <= rd_mux;
    end
  end

  // ==========================================================================
  // Checks
  // ==========================================================================
  sequence fault_seen_s;
    any_fault;
  endsequence
  sequence drives_off_s;
    !o_relay_energise && (o_axis_enable == '0);
  endsequence

  limit_relay_drop_a: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    limit_fault |=> !o_relay_energise) else $error("relay held during limit");
  limit_zero_setpt_a: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    limit_fault |=> (o_setpoint[DACW-1:0] == DACW'(`AFS_SETPT_ZERO)))
    else $error("setpoint not zeroed on limit");
  limit_display_a: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    limit_fault |=> (o_display == `AFS_DISP_L)) else $error("display not L");
  limit_code_a: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    limit_fault |-> (err_code == `AFS_ERR_LIMIT)) else $error("wrong limit code");
  // The synchroniser holds its reset value for two edges, so the pin history is only
  // meaningful once reset has been released for two cycles.
  limit_read_a: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    $past(i_resetn, 2) |-> (limit_active[0] == !$past(i_limit_pin[0], 2)))
    else $error("limit read wrong");
  datum_nofault_a: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    (state == AFS_RUN && datum_active != '0 && !limit_fault && !drive_active && !prog_err
     && !follow_err) |=> o_relay_energise) else $error("datum caused trip");
  relay_no_fault_a: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    o_relay_energise |-> !$past(any_fault)) else $error("relay on with fault");
  fault_drop_a: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    fault_seen_s |=> drives_off_s) else $error("fault did not stop axes");
  hold_until_clear_a: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    (state == AFS_HOLD && !clear_req) |=> (state == AFS_HOLD))
    else $error("left hold without clear");
  drive_off_pol_a: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    (fault_input_polarity == AFS_POL_OFF) |-> !drive_active)
    else $error("disabled fault input active");
endmodule : afs_top

//--- tb/afs_field.sv
// Field-side model: series limit switches, datum switches and a drive fault line.
`timescale 1ns/1ps
module afs_field #(
  parameter int NAXES = 3
) (
  input  wire logic [NAXES-1:0] i_lo_open,
  input  wire logic [NAXES-1:0] i_hi_open,
  input  wire logic [NAXES-1:0] i_datum_open,
  input  wire logic             i_drive_level,
  output logic      [NAXES-1:0] o_limit_pin,
  output logic      [NAXES-1:0] o_datum_pin,
  output logic                  o_drive_fault_pin
);
  // Both end switches of an axis sit in series on one pin, so either one breaks it.
  assign o_limit_pin = ~(i_lo_open | i_hi_open);
  // An open or unwired switch leaves the pin to the pull-down, which reads low.
  assign o_datum_pin = ~i_datum_open;
  // The drive line is driven hard by the external equipment.
  assign o_drive_fault_pin = i_drive_level;
endmodule : afs_field

//--- tb/testbench.sv
// Self-checking bench for the axis fault supervisor.
`timescale 1ns/1ps
`include "afs_consts.svh"
module testbench;
  import afs_pkg::*;
  logic        i_clk_sys, i_resetn, i_psel, i_penable, i_pwrite, o_pready, o_pslverr;
  logic [11:0] i_paddr;
  logic [31:0] i_pwdata, o_prdata, rd;
  logic [2:0]  lim_pin, dat_pin, lo_open, hi_open, dat_open, o_axis_enable;
  logic        drv_pin, drv_lvl, o_relay_energise, err;
  logic [35:0] o_setpoint;
  logic [7:0]  o_display;
  afs_state_t  o_state;
  logic [8:0]  tbl [9];
  int          n_mismatch, cmp_count;

  // ==========================================================
  // Design, field model and clock
  afs_top afs_top_inst (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
    .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .i_limit_pin(lim_pin), .i_datum_pin(dat_pin), .i_drive_fault_pin(drv_pin),
    .o_relay_energise(o_relay_energise), .o_axis_enable(o_axis_enable),
    .o_setpoint(o_setpoint), .o_display(o_display), .o_state(o_state));
  afs_field afs_field_inst (.i_lo_open(lo_open), .i_hi_open(hi_open),
    .i_datum_open(dat_open), .i_drive_level(drv_lvl), .o_limit_pin(lim_pin),
    .o_datum_pin(dat_pin), .o_drive_fault_pin(drv_pin));

  // The clock toggles every half period of 20 ns.
  initial begin
    i_clk_sys = 1'b0;
    forever #20 i_clk_sys = ~i_clk_sys;
  end

  // ==========================================================
  // Shared tasks
  task automatic chk(input string name, input logic [35:0] seen, input logic [35:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // One APB transfer; the request is held until pready is sampled high.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge i_clk_sys);
    i_psel <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk_sys);
    i_penable <= 1'b1;
    do @(posedge i_clk_sys); while (o_pready !== 1'b1);
    rd = o_prdata;
    err = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask : apb

  // Waits whole cycles, then steps past the edge so registered outputs have landed.
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk_sys);
    #1;
  endtask : tick

  task automatic outs(input logic rel, input logic [7:0] disp, input afs_state_t st);
    chk("relay", o_relay_energise, rel);
    chk("enable", o_axis_enable, {3{rel}});
    chk("display", o_display, disp);
    chk("state", o_state, st);
  endtask : outs

  task automatic end_of_test;
    if (n_mismatch == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test

  // A hang is cut short well beyond the length of the sequence.
  initial begin
    #400000;
    n_mismatch++;
    end_of_test();
  end

  // ==========================================================
  // Main sequence
  initial begin
    {i_psel, i_penable, i_pwrite, i_paddr, i_pwdata} = '0;
    {lo_open, hi_open, drv_lvl, i_resetn} = '0;
    dat_open = 3'h7;
    n_mismatch = 0;
    cmp_count = 0;
    tbl = '{{4'h0, 1'b1, 4'h0}, {4'h0, 1'b0, 4'h0}, {4'h2, 1'b1, 4'h6}, {4'h2, 1'b0, 4'h0},
            {4'h1, 1'b0, 4'h6}, {4'h1, 1'b1, 4'h0}, {4'h3, 1'b1, 4'h6}, {4'h4, 1'b1, 4'h5},
            {4'h8, 1'b1, 4'h4}};
    repeat (8) @(posedge i_clk_sys);
    i_resetn <= 1'b1;
    tick(3);
    outs(1'b0, `AFS_DISP_E, AFS_HOLD);
    chk("setpt", o_setpoint, {3{`AFS_SETPT_ZERO}});
    // Unwired datum inputs read active but never fault; clearing starts the run.
    apb(1'b1, `AFS_OFF_CLEAR, 32'h1);
    tick(2);
    outs(1'b1, `AFS_DISP_OK, AFS_RUN);
    apb(1'b0, `AFS_OFF_INPUTS, 32'h0);
    chk("inputs", rd[6:0], 7'h38);
    for (int i = 0; i < 3; i++) apb(1'b1, 12'(`AFS_OFF_SETPT0 + 4 * i), 32'h100 + i);
    tick(2);
    chk("setpt", o_setpoint, {12'h102, 12'h101, 12'h100});
    // Open the low end of axis 1; the synchroniser delays the trip.
    // Closing datum switch 1 leaves only axes 0 and 2 reading active.
    @(posedge i_clk_sys);
    lo_open <= 3'h2;
    dat_open <= 3'h5;
    tick(2);
    chk("relay", o_relay_energise, 1'b1);
    tick(2);
    outs(1'b0, `AFS_DISP_L, AFS_TRIP);
    chk("setpt", o_setpoint, {3{`AFS_SETPT_ZERO}});
    apb(1'b0, `AFS_OFF_STATUS, 32'h0);
    chk("code", rd[3:0], `AFS_ERR_LIMIT);
    apb(1'b0, `AFS_OFF_INPUTS, 32'h0);
    chk("inputs", rd[2:0], 3'h2);
    chk("datum", rd[5:3], 3'h5);
    // The high end shares the pin; clearing while it is open is ignored.
    @(posedge i_clk_sys);
    lo_open <= 3'h0;
    hi_open <= 3'h2;
    apb(1'b1, `AFS_OFF_CLEAR, 32'h1);
    tick(4);
    outs(1'b0, `AFS_DISP_L, AFS_TRIP);
    @(posedge i_clk_sys);
    hi_open <= 3'h0;
    tick(4);
    chk("relay", o_relay_energise, 1'b0);
    // Drive fault polarity modes and software-raised faults.
    foreach (tbl[i]) begin
      @(posedge i_clk_sys);
      drv_lvl <= tbl[i][4];
      apb(1'b1, `AFS_OFF_CTRL, {28'h0, tbl[i][8:5]});
      apb(1'b1, `AFS_OFF_CLEAR, 32'h1);
      tick(4);
      apb(1'b0, `AFS_OFF_STATUS, 32'h0);
      chk("code", rd[3:0], tbl[i][3:0]);
      chk("relay", o_relay_energise, tbl[i][3:0] == 4'h0);
      chk("enable", o_axis_enable, {3{tbl[i][3:0] == 4'h0}});
      apb(1'b1, `AFS_OFF_CTRL, 32'h0);
    end
    // An unmapped address is refused and reads zero.
    apb(1'b0, 12'hffc, 32'h0);
    chk("pslverr", err, 1'b1);
    chk("rdata", rd, 32'h0);
    end_of_test();
  end
endmodule : testbench
